//--- pstp_regs_defs.vh
// Constants for the per-port spanning-tree and PTP timestamp registers.
// Assumes APB byte addresses equal to four times the register index.
`ifndef PSTP_REGS_DEFS_VH
`define PSTP_REGS_DEFS_VH

// ****************************************
// Geometry
// ****************************************
`define PSTP_NPORT 3
`define PSTP_NINST 8
`define PSTP_AW 18
`define PSTP_CORR_W 64
`define PSTP_CORR_FRAC 16

// ****************************************
// Register indexes within a port (low 12 bits)
// ****************************************
`define PSTP_IDX_PTR 12'hB01
`define PSTP_IDX_STATE 12'hB04
`define PSTP_IDX_RXLAT 12'hC00
`define PSTP_IDX_TXLAT 12'hC02
`define PSTP_IDX_ASYM 12'hC04
`define PSTP_IDX_REQ_HI 12'hC08
`define PSTP_IDX_REQ_LO 12'hC0A
`define PSTP_IDX_SYNC_HI 12'hC0C
`define PSTP_IDX_SYNC_LO 12'hC0E
`define PSTP_IDX_RESP_HI 12'hC10
`define PSTP_IDX_RESP_LO 12'hC12
`define PSTP_IDX_STAT 12'hC14
`define PSTP_IDX_IEN 12'hC16
`define PSTP_IDX_ICLR 12'hC1C

// ****************************************
// Fields
// ****************************************
`define PSTP_ST_TX 2
`define PSTP_ST_RX 1
`define PSTP_ST_LRN 0
`define PSTP_ASYM_SIGN 15
`define PSTP_FLAG_SYNC 15
`define PSTP_FLAG_REQ 14
`define PSTP_FLAG_RESP 13

// ****************************************
// Reset values
// ****************************************
`define PSTP_RST_PTR 8'h00
`define PSTP_RST_STATE 3'h6
`define PSTP_RST_RXLAT 16'h019F
`define PSTP_RST_TXLAT 16'h002D
`define PSTP_RST_ZERO16 16'h0000

`endif

//--- pstp_regs.v
// Three-port spanning-tree state and PTP timestamp register bank on APB.
// Assumes a free-running nanosecond time input and one-cycle egress
// strobes from the MAC; correction fields are in ns scaled by 2^16.
//
// Summary of operation
// - An eight-bit pointer per port picks with its low three bits one of eight spanning-tree instances for state register access.
// - Each port keeps eight state copies and every access touches only the pointed copy.
// - State bit 2 enables transmission on the port and resets to one.
// - State bit 1 enables reception on the port and resets to one.
// - State bit 0 set stops address learning and resets to zero.
// - A 16-bit receive latency in ns is writable and resets to 415.
// - A 16-bit transmit latency in ns is writable and resets to 45.
// - Bit 15 of the asymmetry register is its sign, one meaning negative, reset zero.
// - The signed asymmetry is added to the correction field of ingress Sync and Pdelay_Resp.
// - The signed asymmetry is subtracted from the correction field of egress Delay_Req and Pdelay_Req.
// - A read-only 32-bit request egress time shows as high and low words, reset zero.
// - A read-only 32-bit Sync egress time shows as high and low words, reset zero.
// - A read-only 32-bit Pdelay_Resp egress time shows as high and low words, reset zero.
// - Each timestamp type has a ready flag set on capture and cleared by writing one.
// - The three ready flags of a port are ORed into one port PTP status.
`include "pstp_regs_defs.vh"

module pstp_regs (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PSTP_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // Time base and egress events, one bit per port
  input wire [31:0] time_ns,
  input wire [`PSTP_NPORT-1:0] egr_sync,
  input wire [`PSTP_NPORT-1:0] egr_req,
  input wire [`PSTP_NPORT-1:0] egr_resp,
  // Correction field path, one lane per port
  input wire [`PSTP_NPORT-1:0] corr_valid,
  input wire [`PSTP_NPORT-1:0] corr_egress,
  input wire [`PSTP_NPORT*`PSTP_CORR_W-1:0] corr_in,
  output reg [`PSTP_NPORT*`PSTP_CORR_W-1:0] corr_out_q,
  output reg [`PSTP_NPORT-1:0] corr_done_q,
  // Port controls
  output reg [`PSTP_NPORT-1:0] tx_enable_q,
  output reg [`PSTP_NPORT-1:0] rx_enable_q,
  output reg [`PSTP_NPORT-1:0] learn_disable_q,
  output reg [`PSTP_NPORT*16-1:0] rx_path_latency_q,
  output reg [`PSTP_NPORT*16-1:0] tx_path_latency_q,
  // Status and interrupt
  output reg [`PSTP_NPORT-1:0] ptp_status_q,
  output reg irq_q
);

  // ****************************************
  // Address decode
  // ****************************************
  function hit;
    input [15:0] idx;
    input [3:0] port;
    input [11:0] off;
    begin
      hit = (idx[15:12] == port) && (idx[11:0] == off);
    end
  endfunction

  // Sign-magnitude asymmetry to two's complement, ns scaled by 2^16
  function [`PSTP_CORR_W-1:0] signed_asym;
    input [15:0] raw;
    reg [`PSTP_CORR_W-1:0] mag;
    begin
      mag = {{(`PSTP_CORR_W-15-`PSTP_CORR_FRAC){1'b0}}, raw[14:0],
        {`PSTP_CORR_FRAC{1'b0}}};
      if (raw[`PSTP_ASYM_SIGN]) begin
        signed_asym = ~mag + {{(`PSTP_CORR_W-1){1'b0}}, 1'b1};
      end else begin
        signed_asym = mag;
      end
    end
  endfunction

  wire [15:0] idx = paddr[`PSTP_AW-1:2];
  wire aligned = (paddr[1:0] == 2'b00);
  // Access phase, first cycle: answer is registered here
  wire acc = psel && penable && !pready_q;
  // Completion edge: writes take effect only here
  wire done = psel && penable && pready_q;
  wire wr = done && pwrite && aligned;

  wire [15:0] rd_w [0:`PSTP_NPORT-1];
  wire [`PSTP_NPORT-1:0] ok_w;
  wire [`PSTP_NPORT-1:0] tx_w;
  wire [`PSTP_NPORT-1:0] rx_w;
  wire [`PSTP_NPORT-1:0] lrn_w;
  wire [`PSTP_NPORT-1:0] stat_w;
  wire [`PSTP_NPORT-1:0] irq_w;
  wire [`PSTP_NPORT*16-1:0] rxl_w;
  wire [`PSTP_NPORT*16-1:0] txl_w;
  wire [`PSTP_NPORT*`PSTP_CORR_W-1:0] corr_w;

  // ****************************************
  // Per-port register group
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `PSTP_NPORT; g = g + 1) begin : port
      localparam [3:0] PN = g + 1;
      reg [7:0] ptr_q;
      reg [2:0] st_q [0:`PSTP_NINST-1];
      reg [15:0] rxl_q;
      reg [15:0] txl_q;
      reg [15:0] asym_q;
      reg [31:0] req_ts_q;
      reg [31:0] sync_time_q;
      reg [31:0] resp_ts_q;
      reg [2:0] flag_q;
      reg [2:0] ien_q;
      reg [15:0] rd;
      reg ok;
      integer i;
      wire [2:0] cur = st_q[ptr_q[2:0]];
      wire [2:0] ev = {egr_sync[g], egr_req[g], egr_resp[g]};
      wire [2:0] clr = {pwdata[`PSTP_FLAG_SYNC], pwdata[`PSTP_FLAG_REQ],
                        pwdata[`PSTP_FLAG_RESP]};
      // Write strobes, one per writable register
      wire wr_ptr = wr && hit(idx, PN, `PSTP_IDX_PTR);
      wire wr_state = wr && hit(idx, PN, `PSTP_IDX_STATE);
      wire wr_rxl = wr && hit(idx, PN, `PSTP_IDX_RXLAT);
      wire wr_txl = wr && hit(idx, PN, `PSTP_IDX_TXLAT);
      wire wr_asym = wr && hit(idx, PN, `PSTP_IDX_ASYM);
      wire wr_ien = wr && hit(idx, PN, `PSTP_IDX_IEN);
      wire clr_hit = wr && hit(idx, PN, `PSTP_IDX_ICLR);
      wire [`PSTP_CORR_W-1:0] sasym = signed_asym(asym_q);
      wire [`PSTP_CORR_W-1:0] cin =
        corr_in[g*`PSTP_CORR_W +: `PSTP_CORR_W];

      // ****************************************
      // Spanning-tree pointer and state copies
      // ****************************************
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ptr_q <= `PSTP_RST_PTR;
        end else if (wr_ptr) begin
          ptr_q <= pwdata[7:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (i = 0; i < `PSTP_NINST; i = i + 1) begin
            st_q[i] <= `PSTP_RST_STATE;
          end
        end else if (wr_state) begin
          st_q[ptr_q[2:0]] <= pwdata[2:0];
        end
      end

      // ****************************************
      // Latency and asymmetry settings
      // ****************************************
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rxl_q <= `PSTP_RST_RXLAT;
        end else if (wr_rxl) begin
          rxl_q <= pwdata[15:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          txl_q <= `PSTP_RST_TXLAT;
        end else if (wr_txl) begin
          txl_q <= pwdata[15:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          asym_q <= `PSTP_RST_ZERO16;
        end else if (wr_asym) begin
          asym_q <= pwdata[15:0];
        end
      end

      // ****************************************
      // Egress timestamps
      // ****************************************
      // Whole 32-bit time in one edge keeps high and low words paired
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          req_ts_q <= {2{`PSTP_RST_ZERO16}};
        end else if (egr_req[g]) begin
          req_ts_q <= time_ns;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_time_q <= {2{`PSTP_RST_ZERO16}};
        end else if (egr_sync[g]) begin
          sync_time_q <= time_ns;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          resp_ts_q <= {2{`PSTP_RST_ZERO16}};
        end else if (egr_resp[g]) begin
          resp_ts_q <= time_ns;
        end
      end

      // ****************************************
      // Ready flags and interrupt enables
      // ****************************************
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ien_q <= 3'h0;
        end else if (wr_ien) begin
          ien_q <= clr;
        end
      end

      // New event wins over a clear in the same cycle
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_q <= 3'h0;
        end else begin
          flag_q <= (flag_q & ~(clr_hit ? clr : 3'h0)) | ev;
        end
      end

      // ****************************************
      // Register read mux
      // ****************************************
      always @* begin
        rd = 16'h0000;
        ok = 1'b1;
        case (1'b1)
          hit(idx, PN, `PSTP_IDX_PTR): rd = {8'h00, ptr_q};
          hit(idx, PN, `PSTP_IDX_STATE): rd = {13'h0000, cur};
          hit(idx, PN, `PSTP_IDX_RXLAT): rd = rxl_q;
          hit(idx, PN, `PSTP_IDX_TXLAT): rd = txl_q;
          hit(idx, PN, `PSTP_IDX_ASYM): rd = asym_q;
          hit(idx, PN, `PSTP_IDX_REQ_HI): rd = req_ts_q[31:16];
          hit(idx, PN, `PSTP_IDX_REQ_LO): rd = req_ts_q[15:0];
          hit(idx, PN, `PSTP_IDX_SYNC_HI): rd = sync_time_q[31:16];
          hit(idx, PN, `PSTP_IDX_SYNC_LO): rd = sync_time_q[15:0];
          hit(idx, PN, `PSTP_IDX_RESP_HI): rd = resp_ts_q[31:16];
          hit(idx, PN, `PSTP_IDX_RESP_LO): rd = resp_ts_q[15:0];
          hit(idx, PN, `PSTP_IDX_STAT): rd = {flag_q, 13'h0000};
          hit(idx, PN, `PSTP_IDX_IEN): rd = {ien_q, 13'h0000};
          hit(idx, PN, `PSTP_IDX_ICLR): rd = 16'h0000;
          default: ok = 1'b0;
        endcase
      end

      // ****************************************
      // Port outputs
      // ****************************************
      assign rd_w[g] = rd;
      assign ok_w[g] = ok;
      assign tx_w[g] = cur[`PSTP_ST_TX];
      assign rx_w[g] = cur[`PSTP_ST_RX];
      assign lrn_w[g] = cur[`PSTP_ST_LRN];
      assign stat_w[g] = |flag_q;
      assign irq_w[g] = |(flag_q & ien_q);
      assign rxl_w[g*16 +: 16] = rxl_q;
      assign txl_w[g*16 +: 16] = txl_q;
      // Ingress adds, egress subtracts the signed asymmetry
      assign corr_w[g*`PSTP_CORR_W +: `PSTP_CORR_W] = corr_egress[g] ?
        (cin - sasym) : (cin + sasym);
    end
  endgenerate

  // ****************************************
  // Read data merge
  // ****************************************
  reg [15:0] rd_any;
  reg ok_any;
  integer p;
  always @* begin
    rd_any = 16'h0000;
    ok_any = 1'b0;
    for (p = 0; p < `PSTP_NPORT; p = p + 1) begin
      rd_any = rd_any | rd_w[p];
      ok_any = ok_any | ok_w[p];
    end
  end

  // ****************************************
  // APB answer, one wait state
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (acc) begin
      pready_q <= 1'b1;
      pslverr_q <= !(ok_any && aligned);
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Read data holds until the next answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (acc) begin
      prdata_q <= (!pwrite && ok_any && aligned) ?
        {16'h0000, rd_any} : 32'h00000000;
    end
  end

  // ****************************************
  // Registered port controls
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enable_q <= {`PSTP_NPORT{1'b1}};
      rx_enable_q <= {`PSTP_NPORT{1'b1}};
      learn_disable_q <= {`PSTP_NPORT{1'b0}};
    end else begin
      tx_enable_q <= tx_w;
      rx_enable_q <= rx_w;
      learn_disable_q <= lrn_w;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_path_latency_q <= {`PSTP_NPORT{`PSTP_RST_RXLAT}};
      tx_path_latency_q <= {`PSTP_NPORT{`PSTP_RST_TXLAT}};
    end else begin
      rx_path_latency_q <= rxl_w;
      tx_path_latency_q <= txl_w;
    end
  end

  // ****************************************
  // Registered status and interrupt
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptp_status_q <= {`PSTP_NPORT{1'b0}};
      irq_q <= 1'b0;
    end else begin
      ptp_status_q <= stat_w;
      irq_q <= |irq_w;
    end
  end

  // ****************************************
  // Registered correction lanes
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_out_q <= {(`PSTP_NPORT*`PSTP_CORR_W){1'b0}};
      corr_done_q <= {`PSTP_NPORT{1'b0}};
    end else begin
      corr_out_q <= corr_w;
      corr_done_q <= corr_valid;
    end
  end

endmodule

//--- pstp_regs_sva.sv
// Port checker for the spanning-tree and timestamp register bank.
// Assumes the bank header is on the include path; bound below.
`include "pstp_regs_defs.vh"
module pstp_regs_sva (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PSTP_AW-1:0] paddr,
  input wire pready_q,
  input wire pslverr_q,
  // Events and outputs
  input wire [`PSTP_NPORT-1:0] egr_sync,
  input wire [`PSTP_NPORT-1:0] egr_req,
  input wire [`PSTP_NPORT-1:0] egr_resp,
  input wire [`PSTP_NPORT-1:0] corr_valid,
  input wire [`PSTP_NPORT-1:0] corr_done_q,
  input wire [`PSTP_NPORT-1:0] tx_enable_q,
  input wire [`PSTP_NPORT-1:0] rx_enable_q,
  input wire [`PSTP_NPORT-1:0] learn_disable_q,
  input wire [`PSTP_NPORT*16-1:0] rx_path_latency_q,
  input wire [`PSTP_NPORT-1:0] ptp_status_q,
  input wire irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [`PSTP_NPORT-1:0] ev = egr_sync | egr_req | egr_resp;
  wire wr = pready_q & pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Assertions
  // ****************************************
  a_answer_time: assert property (psel && penable && !$past(penable)
    |=> pready_q) else $error("answer not in second access cycle");
  a_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready_q |-> psel && penable)
    else $error("ready outside access");
  a_err_misalign: assert property (psel && penable && !pready_q &&
    paddr[1:0] != 0 |=> pready_q && pslverr_q)
    else $error("misaligned access not refused");
  a_status_event: assert property (ev != 0 |-> ##2
    (ptp_status_q & $past(ev, 2)) == $past(ev, 2))
    else $error("egress event not shown in status");
  a_irq_cause: assert property (irq_q |-> ptp_status_q != 0)
    else $error("interrupt without status");
  a_lat_cause: assert property ($changed(rx_path_latency_q)
    |-> $past(wr, 2)) else $error("latency changed without write");
  a_ctrl_cause: assert property ($changed({tx_enable_q,
    rx_enable_q, learn_disable_q}) |-> $past(wr) || $past(wr, 2))
    else $error("port control changed without write");
  a_corr_done: assert property (corr_valid != 0
    |=> corr_done_q == $past(corr_valid))
    else $error("correction not done next cycle");
  c_irq: cover property (irq_q);
  c_err: cover property (pready_q && pslverr_q);
  c_corr: cover property (corr_done_q != 0);
endmodule

bind pstp_regs pstp_regs_sva u_pstp_regs_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pready_q, .pslverr_q, .egr_sync, .egr_req,
  .egr_resp, .corr_valid, .corr_done_q, .tx_enable_q, .rx_enable_q,
  .learn_disable_q, .rx_path_latency_q, .ptp_status_q, .irq_q);

//--- pstp_link_model.sv
// Link-side model: egress strobes and correction field lanes.
// Assumes the bank samples its inputs on the rising edge of pclk.
module pstp_link_model (
  // Clock
  input wire pclk,
  // Egress strobes, bit p for port p+1
  output logic [2:0] egr_sync = 0,
  output logic [2:0] egr_req = 0,
  output logic [2:0] egr_resp = 0,
  // Correction lanes
  output logic [2:0] corr_valid = 0,
  output logic [2:0] corr_egress = 0,
  output logic [191:0] corr_in = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Frame tasks
  // ****************************************
  task automatic egress(input int k, input int p);
    @(posedge pclk);
    egr_sync[p] <= (k == 0);
    egr_req[p] <= (k == 1);
    egr_resp[p] <= (k == 2);
    @(posedge pclk);
    egr_sync <= 0;
    egr_req <= 0;
    egr_resp <= 0;
  endtask
  task automatic corr(input int p, input e, input [63:0] v);
    @(posedge pclk);
    corr_valid[p] <= 1'b1;
    corr_egress[p] <= e;
    corr_in[64*p +: 64] <= v;
    @(posedge pclk);
    corr_valid <= 0;
    corr_in <= ~corr_in;
  endtask
endmodule

//--- pstp_regs_tb.sv
// Self-checking bench for the register bank over APB.
// Assumes the checker and link model files are compiled first.
`include "pstp_regs_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pstp_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, time_ns = 0, rd;
  logic [11:0] hi [3] = '{`PSTP_IDX_SYNC_HI, `PSTP_IDX_REQ_HI,
    `PSTP_IDX_RESP_HI};
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, irq_q;
  wire [2:0] egr_sync, egr_req, egr_resp, corr_valid, corr_egress;
  wire [2:0] corr_done_q, tx_enable_q, rx_enable_q, learn_disable_q;
  wire [2:0] ptp_status_q;
  wire [191:0] corr_in, corr_out_q;
  wire [47:0] rx_path_latency_q, tx_path_latency_q;
  int failures = 0, total_checks = 0;
  pstp_regs u_pstp_regs (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .time_ns,
    .egr_sync, .egr_req, .egr_resp, .corr_valid, .corr_egress, .corr_in,
    .corr_out_q, .corr_done_q, .tx_enable_q, .rx_enable_q,
    .learn_disable_q, .rx_path_latency_q, .tx_path_latency_q,
    .ptp_status_q, .irq_q);
  pstp_link_model u_pstp_link_model (.pclk, .egr_sync, .egr_req,
    .egr_resp, .corr_valid, .corr_egress, .corr_in);
  // ****************************************
  // Bus tasks and run
  // ****************************************
  initial forever #4 pclk = ~pclk;
  function automatic [17:0] ad(input [3:0] p, input [11:0] o);
    ad = {p, o, 2'b00};
  endfunction
  task automatic xfer(input w, input [17:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready_q !== 1'b1 && ++n < 50);
    if (n >= 50) failures++;
    rd = prdata_q;
    err = pslverr_q;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input [17:0] a, input [31:0] e);
    xfer(0, a, 0);
    `CHK(rd, e)
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    `CHK(rx_path_latency_q, {3{16'h019F}})
    `CHK(tx_path_latency_q, {3{16'h002D}})
    `CHK({tx_enable_q, rx_enable_q, learn_disable_q}, 9'h1F8)
    rchk(ad(3, `PSTP_IDX_ASYM), 0);
    for (int k = 0; k < 6; k++)
      rchk(ad(3, 12'(`PSTP_IDX_REQ_HI + 2 * k)), 0);
    rchk(ad(1, `PSTP_IDX_STATE), 32'h6);
    rchk(ad(2, `PSTP_IDX_TXLAT), 32'h2D);
    for (int i = 0; i < 8; i++) begin
      xfer(1, ad(1, `PSTP_IDX_PTR), 32'(i));
      xfer(1, ad(1, `PSTP_IDX_STATE), 32'(7 - i));
    end
    for (int i = 0; i < 8; i++) begin
      xfer(1, ad(1, `PSTP_IDX_PTR), 32'hF8 | i);
      rchk(ad(1, `PSTP_IDX_STATE), 32'(7 - i));
      `CHK({tx_enable_q[0], rx_enable_q[0], learn_disable_q[0]}, 3'(7 - i))
    end
    rchk(ad(1, `PSTP_IDX_PTR), 32'hFF);
    rchk(ad(2, `PSTP_IDX_STATE), 32'h6);
    xfer(1, ad(2, `PSTP_IDX_RXLAT), 32'h1234);
    rchk(ad(2, `PSTP_IDX_RXLAT), 32'h1234);
    `CHK(rx_path_latency_q, {16'h019F, 16'h1234, 16'h019F})
    xfer(1, ad(3, `PSTP_IDX_TXLAT), 32'hABC);
    rchk(ad(3, `PSTP_IDX_TXLAT), 32'hABC);
    `CHK(tx_path_latency_q[47:32], 16'h0ABC)
    xfer(0, ad(1, 12'hC20), 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    xfer(0, ad(1, `PSTP_IDX_RXLAT) | 18'h1, 0);
    `CHK(err, 1'b1)
    xfer(1, ad(1, `PSTP_IDX_SYNC_HI), 32'hFFFF);
    rchk(ad(1, `PSTP_IDX_SYNC_HI), 0);
    for (int k = 0; k < 3; k++) begin
      time_ns <= 32'hABCD0000 + k;
      u_pstp_link_model.egress(k, k);
      time_ns <= 0;
      rchk(ad(4'(k + 1), hi[k]), 32'hABCD);
      rchk(ad(4'(k + 1), hi[k] + 12'h2), 32'(k));
      rchk(ad(4'(k + 1), `PSTP_IDX_STAT), 32'h8000 >> k);
      `CHK({irq_q, ptp_status_q}, {1'b0, 3'(1 << k)})
      xfer(1, ad(4'(k + 1), `PSTP_IDX_IEN), 32'h8000 >> k);
      repeat (2) @(posedge pclk);
      `CHK(irq_q, 1'b1)
      xfer(1, ad(4'(k + 1), `PSTP_IDX_ICLR), 32'h8000 >> k);
      repeat (2) @(posedge pclk);
      `CHK({irq_q, ptp_status_q}, 4'h0)
    end
    xfer(1, ad(1, `PSTP_IDX_ASYM), 32'h8005);
    rchk(ad(1, `PSTP_IDX_ASYM), 32'h8005);
    u_pstp_link_model.corr(0, 0, 64'h100000);
    #1;
    `CHK(corr_out_q[63:0], 64'hB0000)
    `CHK(corr_done_q, 3'h1)
    u_pstp_link_model.corr(0, 1, 64'h100000);
    #1;
    `CHK(corr_out_q[63:0], 64'h150000)
    summarize();
  end
endmodule
